// ==== logic/bic_ctrl.v ====
`timescale 1ns/1ps
`include "bic_map.vh"

// ==========================================================================
// Bootstrap initialization and bias control
// ==========================================================================
module bic_ctrl #(
    parameter [19:0] END_CYC = `BIC_END_CYC,
    parameter [13:0] STEP_CYC = `BIC_STEP_CYC
) (
    // Clock and reset.
    input wire core_clk_in,
    input wire nrst_in,
    // Register port from the serial interface.
    input wire [`BIC_ADDR_W-1:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [15:0] reg_wdata_in,
    output reg [15:0] reg_rdata_out,
    // Microcore bias write port.
    input wire uc_wr_in,
    input wire [15:0] uc_wdata_in,
    input wire [10:0] uc_access_in,
    // Supply and strap.
    input wire pump_supply_undervoltage_in,
    input wire debug_strap_pin_in,
    input wire supply_ext_enable_setting_in,
    // Analog comparators per high-side driver.
    input wire [4:0] bs_ready_in,
    input wire [4:0] clamp_active_in,
    input wire [4:0] src_below_thr_in,
    input wire [4:0] highside_on_in,
    // Coupling configuration and low-side activity.
    input wire [4:0] coupling_disable_in,
    input wire [34:0] coupling_share_in,
    input wire [6:0] lowside_on_in,
    // Programmed source thresholds, three bits per driver.
    input wire [14:0] src_thr_prog_in,
    // Drive towards the pre-driver stages.
    output reg [4:0] highside_pullup_enable_out,
    output reg [1:0] highside_strong_pullup_enable_out,
    output reg [5:0] lowside_pulldown_enable_out,
    output reg [4:0] init_current_limit_out,
    output reg [14:0] src_thr_out,
    output reg supply_ext_enable_out,
    output reg [4:0] coupled_lowside_active_out
);

    // ======================================================================
    // Declarations
    // ======================================================================
    reg [12:0] bias_q;
    reg [12:0] bias_d;
    reg [12:0] uc_mask;
    reg strap_q;
    reg [1:0] state_q [0:4];
    reg [4:0] raised_threshold_used_q;
    wire [4:0] in_init;
    wire [4:0] in_high;
    wire [4:0] coupled;
    wire [4:0] finish;
    wire any_init;
    wire supply_ok;
    wire [5:0] timer_field;
    wire timer_expired;
    reg timer_expired_q;
    wire timer_end;
    wire [4:0] capacitor_uncharged_flag;
    wire [12:0] bias_eff;
    wire [15:0] status_word;

    // The undervoltage flag is taken as already synchronous to the core clock; a raw
    // comparator output would need a synchroniser in front of this block.
    assign supply_ok = ~pump_supply_undervoltage_in;
    // The end event is one cycle: the first cycle the timer shows expiry.
    assign timer_end = timer_expired & ~timer_expired_q;

    // ======================================================================
    // Global timer
    // ======================================================================
    // one timer for all drivers
    bic_timer #(
        .END_CYC(END_CYC),
        .STEP_CYC(STEP_CYC)
    ) u_timer (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .run_in(supply_ok),
        .field_out(timer_field),
        .expired_out(timer_expired)
    );

    // Edge tracking for the timer end event.
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            timer_expired_q <= 1'b0;
        end else begin
            timer_expired_q <= timer_expired;
        end
    end

    // ======================================================================
    // Debug strap capture
    // ======================================================================
    // The strap follows the pin while reset is held and freezes at release.
    // A strap change after release has no effect until the next reset.
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            strap_q <= debug_strap_pin_in;
        end
    end

    // ======================================================================
    // Per-driver initialization state machines
    // ======================================================================
    genvar g;
    generate
        for (g = 0; g < `BIC_NUM_HS; g = g + 1) begin : g_drv
            assign coupled[g] = coupling_disable_in[g] |
                                (|(lowside_on_in & coupling_share_in[g*7 +: 7]));
            assign finish[g] = (bs_ready_in[g] & src_below_thr_in[g]) |
                               (clamp_active_in[g] & src_below_thr_in[g]) |
                               coupled[g] | highside_on_in[g];
            assign in_init[g] = (state_q[g] != `BIC_ST_DONE);
            assign in_high[g] = (state_q[g] == `BIC_ST_INIT_HIGH);
            assign capacitor_uncharged_flag[g] = in_init[g];

            // Termination wins over the threshold raise in the same cycle, so the
            // raised flag only marks drivers that truly needed 1.0 V.
            always @(posedge core_clk_in) begin
                if (!nrst_in) begin
                    state_q[g] <= `BIC_ST_WAIT;
                    raised_threshold_used_q[g] <= 1'b0;
                end else begin
                    case (state_q[g])
                        `BIC_ST_WAIT: begin
                            // No termination is looked at before the pump supply is good,
                            // since the comparators cannot be trusted while it ramps.
                            // enter low-threshold init
                            if (supply_ok) begin
                                state_q[g] <= `BIC_ST_INIT_LOW;
                            end
                        end
                        `BIC_ST_INIT_LOW: begin
                            if (finish[g]) begin
                                state_q[g] <= `BIC_ST_DONE;
                            end else if (timer_end) begin
                                state_q[g] <= `BIC_ST_INIT_HIGH;
                                raised_threshold_used_q[g] <= 1'b1;
                            end
                        end
                        `BIC_ST_INIT_HIGH: begin
                            if (finish[g]) begin
                                state_q[g] <= `BIC_ST_DONE;
                            end
                        end
                        `BIC_ST_DONE: begin
                            // Done is sticky: a later supply dip does not restart this driver.
                            state_q[g] <= `BIC_ST_DONE;
                        end
                        default: begin
                            state_q[g] <= `BIC_ST_WAIT;
                        end
                    endcase
                end
            end
        end
    endgenerate

    assign any_init = |in_init;

    // ======================================================================
    // Bias register writes
    // ======================================================================
    // Each bias bit follows the access right of the output it drives; the
    // strong pull-ups share the right of their own high-side.
    always @* begin
        uc_mask = {uc_access_in[3], uc_access_in[1], uc_access_in[10:0]};
    end

    // Serial writes have full access and win over a microcore write in the same cycle.
    always @* begin
        bias_d = bias_q;
        if (reg_wr_in && reg_addr_in == `BIC_OFS_BIAS) begin
            bias_d = reg_wdata_in[12:0];
        end else if (uc_wr_in) begin
            bias_d = (bias_q & ~uc_mask) | (uc_wdata_in[12:0] & uc_mask);
        end
    end

    // Stored bias configuration.
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            bias_q <= `BIC_BIAS_RST;
        end else begin
            bias_q <= bias_d;
        end
    end

    // ======================================================================
    // Effective bias and drive outputs
    // ======================================================================
    // pull-up off while initializing
    // strong pull-ups on HS2 and HS4
    assign bias_eff[4:0] = bias_q[4:0] & ~in_init;
    assign bias_eff[10:5] = any_init ? 6'h3f : bias_q[10:5];
    assign bias_eff[11] = bias_q[`BIC_BIAS_HS2_SPU] & ~in_init[1];
    assign bias_eff[12] = bias_q[`BIC_BIAS_HS4_SPU] & ~in_init[3];

    // All drive outputs are registered so the analog side sees clean levels.
    // The price is one cycle of lag behind every state change, far below any analog time.
    integer k;
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            highside_pullup_enable_out <= 5'h00;
            highside_strong_pullup_enable_out <= 2'h0;
            lowside_pulldown_enable_out <= 6'h3f;
            init_current_limit_out <= 5'h1f;
            src_thr_out <= {5{`BIC_THR_0V5}};
            supply_ext_enable_out <= 1'b0;
            coupled_lowside_active_out <= 5'h00;
        end else begin
            highside_pullup_enable_out <= bias_eff[4:0];
            highside_strong_pullup_enable_out <= bias_eff[12:11];
            lowside_pulldown_enable_out <= bias_eff[10:5];
            init_current_limit_out <= in_init;
            supply_ext_enable_out <= (any_init && strap_q) ? 1'b0 :
                                     supply_ext_enable_setting_in;
            coupled_lowside_active_out <= coupled;
            for (k = 0; k < `BIC_NUM_HS; k = k + 1) begin
                if (in_high[k]) begin
                    src_thr_out[k*3 +: 3] <= `BIC_THR_1V0;
                end else if (in_init[k]) begin
                    src_thr_out[k*3 +: 3] <= `BIC_THR_0V5;
                end else begin
                    src_thr_out[k*3 +: 3] <= src_thr_prog_in[k*3 +: 3];
                end
            end
        end
    end

    // ======================================================================
    // Register reads
    // ======================================================================
    // timer field in top bits
    assign status_word = {timer_field, raised_threshold_used_q, capacitor_uncharged_flag};

    // Read data is held until the next read; unmapped offsets read zero.
    // The status offset is read only, so the write decode never names it.
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `BIC_OFS_BIAS: begin
                    reg_rdata_out <= {3'h0, bias_eff};
                end
                `BIC_OFS_STATUS: begin
                    reg_rdata_out <= status_word;
                end
                default: begin
                    reg_rdata_out <= 16'h0000;
                end
            endcase
        end
    end

endmodule // bic_ctrl

// ==== logic/bic_map.vh ====
`ifndef BIC_MAP_VH
`define BIC_MAP_VH

// ==========================================================================
// Register offsets and field positions
// ==========================================================================
`define BIC_ADDR_W 10
`define BIC_OFS_BIAS 10'h1a4
`define BIC_OFS_STATUS 10'h1a5
// Bias register fields.
`define BIC_BIAS_HS_PU_LSB 0
`define BIC_BIAS_LS_PD_LSB 5
`define BIC_BIAS_HS2_SPU 11
`define BIC_BIAS_HS4_SPU 12
`define BIC_BIAS_RST 13'h0000
// Status register fields.
`define BIC_STAT_UNCHG_LSB 0
`define BIC_STAT_SRC1V_LSB 5
`define BIC_STAT_TIMER_LSB 10

// ==========================================================================
// Driver counts and state codes
// ==========================================================================
`define BIC_NUM_HS 5
`define BIC_NUM_LS_PD 6
`define BIC_NUM_LS 7
`define BIC_ST_WAIT 2'h0
`define BIC_ST_INIT_LOW 2'h1
`define BIC_ST_INIT_HIGH 2'h2
`define BIC_ST_DONE 2'h3

// ==========================================================================
// Source threshold codes (plain defaults, analog trim decides the meaning)
// ==========================================================================
`define BIC_THR_0V5 3'h1
`define BIC_THR_1V0 3'h2

// ==========================================================================
// Timing
// ==========================================================================
`define BIC_CLK_MHZ 20
`define BIC_STEP_NS 670000
`define BIC_END_NS 36000000
// Cycle counts at 20 MHz, sized to the counters that hold them.
`define BIC_STEP_CYC 14'd13400
`define BIC_END_CYC 20'd720000
`define BIC_TMR_FINAL 6'h34
`define BIC_TMR_LAST_RUN 6'h33

`endif

// ==== logic/bic_timer.v ====
`timescale 1ns/1ps
`include "bic_map.vh"

// ==========================================================================
// Global bootstrap initialization timer
// ==========================================================================
module bic_timer #(
    parameter [19:0] END_CYC = `BIC_END_CYC,
    parameter [13:0] STEP_CYC = `BIC_STEP_CYC
) (
    // Clock and reset.
    input wire core_clk_in,
    input wire nrst_in,
    // Run while the pump supply is good.
    input wire run_in,
    // Visible field and expiry.
    output reg [5:0] field_out,
    output reg expired_out
);

    reg [19:0] cyc_q;
    reg [13:0] step_q;

    // The timer restarts from zero whenever undervoltage returns, so the field reads zero then.
    // field reads zero under undervoltage
    always @(posedge core_clk_in) begin
        if (!nrst_in || !run_in) begin
            cyc_q <= 20'h00000;
            step_q <= 14'h0000;
            field_out <= 6'h00;
            expired_out <= 1'b0;
        end else if (!expired_out) begin
            cyc_q <= cyc_q + 20'h00001;
            if (step_q == STEP_CYC - 14'h0001) begin
                step_q <= 14'h0000;
                if (field_out != `BIC_TMR_LAST_RUN && field_out != `BIC_TMR_FINAL) begin
                    field_out <= field_out + 6'h01;
                end
            end else begin
                step_q <= step_q + 14'h0001;
            end
            // The end count comes last so it wins over a step in the same cycle.
            // end count reached
            if (cyc_q == END_CYC - 20'h00001) begin
                expired_out <= 1'b1;
                field_out <= `BIC_TMR_FINAL;
            end
        end
    end

endmodule // bic_timer

// ==== tb/bic_ctrl_monitor.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the bootstrap init and bias block
// ==========================================================================
module bic_ctrl_monitor (
    // Clock, reset and register port.
    input wire core_clk_in,
    input wire nrst_in,
    input wire [9:0] reg_addr_in,
    input wire reg_rd_in,
    input wire [15:0] reg_rdata_out,
    input wire uc_wr_in,
    // Supply, strap and analog inputs.
    input wire pump_supply_undervoltage_in,
    input wire debug_strap_pin_in,
    input wire [4:0] highside_on_in,
    input wire [4:0] coupling_disable_in,
    input wire [14:0] src_thr_prog_in,
    // Outputs towards the pre-driver stages.
    input wire [4:0] highside_pullup_enable_out,
    input wire [1:0] highside_strong_pullup_enable_out,
    input wire [5:0] lowside_pulldown_enable_out,
    input wire [4:0] init_current_limit_out,
    input wire [14:0] src_thr_out,
    input wire supply_ext_enable_out,
    input wire [4:0] coupled_lowside_active_out
);
    reg strap_q;
    // The strap only counts as last seen during reset, so keep that copy.
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            strap_q <= debug_strap_pin_in;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    property p_pd_forced;
        (|init_current_limit_out) |-> lowside_pulldown_enable_out == 6'h3f;
    endproperty
    a_pd_forced: assert property (p_pd_forced) else $error("pull-downs not forced");
    property p_pu_masked;
        (init_current_limit_out & highside_pullup_enable_out) == 5'h00;
    endproperty
    a_pu_masked: assert property (p_pu_masked) else $error("pull-up during init");
    property p_strong_masked;
        (highside_strong_pullup_enable_out & {init_current_limit_out[3],
            init_current_limit_out[1]}) == 2'h0;
    endproperty
    a_strong_masked: assert property (p_strong_masked) else $error("strong pull-up on");
    property p_ext_internal;
        (|init_current_limit_out) && strap_q |-> !supply_ext_enable_out;
    endproperty
    a_ext_internal: assert property (p_ext_internal) else $error("supply not internal");
    property p_thr_init;
        init_current_limit_out[0] |-> src_thr_out[2:0] inside {3'h1, 3'h2};
    endproperty
    a_thr_init: assert property (p_thr_init) else $error("init threshold wrong");
    property p_thr_restore;
        !init_current_limit_out[0] && $stable(src_thr_prog_in)
            |-> src_thr_out[2:0] == src_thr_prog_in[2:0];
    endproperty
    a_thr_restore: assert property (p_thr_restore) else $error("threshold not restored");
    property p_coupling;
        $past(nrst_in) |-> (coupled_lowside_active_out & $past(coupling_disable_in))
            == $past(coupling_disable_in);
    endproperty
    a_coupling: assert property (p_coupling) else $error("coupling not forced");
    property p_hs_on_ends;
        $rose(highside_on_in[1]) |-> ##[1:3] !init_current_limit_out[1];
    endproperty
    a_hs_on_ends: assert property (p_hs_on_ends) else $error("switch-on kept init");
    property p_timer_zero;
        pump_supply_undervoltage_in[*2] ##0 (reg_rd_in && reg_addr_in == 10'h1a5)
            |=> reg_rdata_out[15:10] == 6'h00;
    endproperty
    a_timer_zero: assert property (p_timer_zero) else $error("timer field not zero");
    property p_uncharged;
        reg_rd_in && reg_addr_in == 10'h1a5 |=> reg_rdata_out[4:0] == init_current_limit_out;
    endproperty
    a_uncharged: assert property (p_uncharged) else $error("charge flags wrong");
    property p_bias_readback;
        reg_rd_in && reg_addr_in == 10'h1a4 |=> reg_rdata_out == {3'h0,
            highside_strong_pullup_enable_out, lowside_pulldown_enable_out,
            highside_pullup_enable_out};
    endproperty
    a_bias_readback: assert property (p_bias_readback) else $error("bias readback");
    c_all_done: cover property (init_current_limit_out == 5'h00);
    c_thr_high: cover property (src_thr_out[11:9] == 3'h2);
    c_uc_write: cover property (uc_wr_in);
endmodule // bic_ctrl_monitor

bind bic_ctrl bic_ctrl_monitor u_mon (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .uc_wr_in(uc_wr_in), .pump_supply_undervoltage_in(pump_supply_undervoltage_in),
    .debug_strap_pin_in(debug_strap_pin_in), .highside_on_in(highside_on_in),
    .coupling_disable_in(coupling_disable_in), .src_thr_prog_in(src_thr_prog_in),
    .highside_pullup_enable_out(highside_pullup_enable_out),
    .highside_strong_pullup_enable_out(highside_strong_pullup_enable_out),
    .lowside_pulldown_enable_out(lowside_pulldown_enable_out),
    .init_current_limit_out(init_current_limit_out), .src_thr_out(src_thr_out),
    .supply_ext_enable_out(supply_ext_enable_out),
    .coupled_lowside_active_out(coupled_lowside_active_out));

// ==== tb/bic_partner.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Analog side model: bootstrap comparators and clamps
// ==========================================================================
module bic_partner #(
    parameter [3:0] DELAY = 4'h4
) (
    // Clock and stimulus from the bench.
    input wire core_clk_in,
    input wire [4:0] charge_in,
    input wire [4:0] clamp_in,
    // Comparator outputs.
    output wire [4:0] bs_ready_out,
    output wire [4:0] clamp_active_out,
    output wire [4:0] src_below_thr_out
);
    reg [3:0] cnt_q [0:4];
    integer g;
    // Charging takes a few cycles so the block never sees an instant answer.
    always @(posedge core_clk_in) begin
        for (g = 0; g < 5; g = g + 1) begin
            if (!charge_in[g]) begin
                cnt_q[g] <= 4'h0;
            end else if (cnt_q[g] != DELAY) begin
                cnt_q[g] <= cnt_q[g] + 4'h1;
            end
        end
    end
    genvar k;
    generate
        for (k = 0; k < 5; k = k + 1) begin : g_drv
            assign bs_ready_out[k] = charge_in[k] && (cnt_q[k] == DELAY);
        end
    endgenerate
    // The source sits low only once charged or clamped.
    assign clamp_active_out = clamp_in;
    assign src_below_thr_out = bs_ready_out | clamp_in;
endmodule // bic_partner

// ==== tb/bic_ctrl_test.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Register-level bench for the bootstrap init and bias block
// ==========================================================================
module bic_ctrl_test;
    reg core_clk_in, nrst_in, reg_wr_in, reg_rd_in, uc_wr_in, uv, strap, ext_set;
    reg [9:0] addr;
    reg [15:0] wdata, uc_wdata, v;
    reg [10:0] uc_access;
    reg [4:0] hs_on, cpl_dis, charge, clamp;
    reg [34:0] share;
    reg [6:0] ls_on;
    reg [14:0] thr_prog;
    wire [15:0] rdata;
    wire [4:0] ready, clamp_act, below, pu, limit, coupled;
    wire [1:0] spu;
    wire [5:0] pd;
    wire [14:0] thr;
    wire ext;
    integer error_cnt = 0, tests_run = 0, cyc = 0, uvcnt = 0;
    bic_ctrl #(.END_CYC(20'd200), .STEP_CYC(14'd3)) DUT (.core_clk_in(core_clk_in),
        .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .uc_wr_in(uc_wr_in),
        .uc_wdata_in(uc_wdata), .uc_access_in(uc_access), .pump_supply_undervoltage_in(uv),
        .debug_strap_pin_in(strap), .supply_ext_enable_setting_in(ext_set),
        .bs_ready_in(ready), .clamp_active_in(clamp_act), .src_below_thr_in(below),
        .highside_on_in(hs_on), .coupling_disable_in(cpl_dis), .coupling_share_in(share),
        .lowside_on_in(ls_on), .src_thr_prog_in(thr_prog),
        .highside_pullup_enable_out(pu), .highside_strong_pullup_enable_out(spu),
        .lowside_pulldown_enable_out(pd), .init_current_limit_out(limit),
        .src_thr_out(thr), .supply_ext_enable_out(ext), .coupled_lowside_active_out(coupled));
    bic_partner u_far (.core_clk_in(core_clk_in), .charge_in(charge), .clamp_in(clamp),
        .bs_ready_out(ready), .clamp_active_out(clamp_act), .src_below_thr_out(below));
    // Clock and a count of good-supply cycles.
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        uvcnt <= (!nrst_in || uv) ? 0 : uvcnt + 1;
        if (cyc == 4000) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
        end
    end
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // A strobe stands for exactly one rising edge.
    task wr(input [9:0] a, input [15:0] d);
        begin
            @(negedge core_clk_in) addr = a;
            wdata = d;
            reg_wr_in = 1'b1;
            @(negedge core_clk_in) reg_wr_in = 1'b0;
        end
    endtask
    task rd(input [9:0] a);
        begin
            @(negedge core_clk_in) addr = a;
            reg_rd_in = 1'b1;
            @(negedge core_clk_in) reg_rd_in = 1'b0;
            v = rdata;
        end
    endtask
    task wait_uv(input integer n);
        while (uvcnt < n) @(negedge core_clk_in);
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Main sequence: every driver leaves init by a different cause.
    initial begin
        {nrst_in, reg_wr_in, reg_rd_in, uc_wr_in, addr, wdata, uc_wdata, uc_access} = 0;
        {hs_on, cpl_dis, charge, clamp, share, ls_on} = 0;
        {uv, strap, ext_set, thr_prog} = {3'h7, 15'h7fff};
        repeat (5) @(negedge core_clk_in);
        nrst_in = 1'b1;
        @(negedge core_clk_in);
        chk(pd, 6'h3f);
        chk(limit, 5'h1f);
        chk(thr, 15'h1249);
        chk(ext, 1'b0);
        rd(10'h1a5); chk(v, 16'h001f);
        wr(10'h1a4, 16'h1555);
        wr(10'h1a5, 16'hffff);
        rd(10'h1a4); chk(v, 16'h07e0);
        rd(10'h1a5); chk(v, 16'h001f);
        rd(10'h1a3); chk(v, 16'h0000);
        cpl_dis = 5'h10;
        uv = 1'b0;
        repeat (4) @(negedge core_clk_in);
        chk(coupled, 5'h10);
        chk(limit, 5'h0f);
        chk(pu, 5'h10);
        chk(thr, 15'h7249);
        chk(pd, 6'h3f);
        charge = 5'h01;
        repeat (10) @(negedge core_clk_in);
        chk(limit, 5'h0e);
        hs_on = 5'h02;
        repeat (4) @(negedge core_clk_in);
        hs_on = 5'h00;
        chk(limit, 5'h0c);
        share = 35'h10000;
        ls_on = 7'h04;
        repeat (4) @(negedge core_clk_in);
        chk(coupled, 5'h14);
        chk(limit, 5'h08);
        ls_on = 7'h00;
        repeat (3) @(negedge core_clk_in);
        chk(coupled, 5'h10);
        wait_uv(175);
        rd(10'h1a5); chk(v, 16'hcc08);
        chk(ext, 1'b0);
        wait_uv(215);
        rd(10'h1a5); chk(v, 16'hd108);
        chk(thr, 15'h75ff);
        clamp = 5'h08;
        repeat (4) @(negedge core_clk_in);
        chk(limit, 5'h00);
        chk(pd, 6'h2a);
        chk(pu, 5'h15);
        chk(spu, 2'h2);
        chk(ext, 1'b1);
        chk(thr, 15'h7fff);
        rd(10'h1a4); chk(v, 16'h1555);
        rd(10'h1a5); chk(v, 16'hd100);
        @(negedge core_clk_in) uc_access = 11'h001;
        uc_wr_in = 1'b1;
        @(negedge core_clk_in) uc_access = 11'h008;
        @(negedge core_clk_in) uc_wr_in = 1'b0;
        rd(10'h1a4); chk(v, 16'h0554);
        // A second reset with the strap low leaves the external setting in force.
        strap = 1'b0;
        nrst_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        nrst_in = 1'b1;
        strap = 1'b1;
        repeat (2) @(negedge core_clk_in);
        chk(limit, 5'h1f);
        chk(ext, 1'b1);
        report_and_stop;
    end
endmodule // bic_ctrl_test
